// *** pkg/soatc_pkg.sv ***
/*
 Constants, register map and types for the serial video output control block.
 Assumes a 10 MHz register clock and 32-bit AHB-Lite word access.
*/
`default_nettype none
package soatc_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ     = 10_000_000;
    localparam int unsigned AV_ON_MS   = 1000;
    localparam int unsigned AV_OFF_MS  = 4000;
    localparam int unsigned AV_ON_CYC  = CLK_HZ / 1000 * AV_ON_MS;
    localparam int unsigned AV_OFF_CYC = CLK_HZ / 1000 * AV_OFF_MS;
    localparam int          AV_W       = 26;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_INIT = 8'h04;
    localparam logic [7:0] A_OFFS = 8'h08;
    localparam logic [7:0] A_IDS  = 8'h0c;
    localparam logic [7:0] A_CNCS = 8'h10;
    localparam logic [7:0] A_LOC  = 8'h14;
    localparam logic [7:0] A_UDW  = 8'h18;
    localparam logic [7:0] A_STAT = 8'h1c;
    localparam logic [7:0] A_TC   = 8'h20;
    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    localparam int C_SRC   = 0;
    localparam int C_APPLY = 1;
    localparam int C_DF    = 2;
    localparam int C_LTC   = 3;
    localparam int C_VITC  = 4;
    localparam int C_COMP  = 5;
    localparam int C_EDGE  = 8;
    localparam int C_AV    = 9;
    localparam int C_MODE  = 10;
    localparam int C_MAN   = 12;
    localparam int C_CSA   = 13;
    localparam int CTRL_W  = 14;
    localparam logic [CTRL_W-1:0] CTRL_RST = 14'h01e0;
    localparam logic [2:0] COMP_ALL_ON = 3'h7;
    localparam int HI_LSB  = 16;
    // ----------------------------------------------------------------
    // Status fields
    // ----------------------------------------------------------------
    localparam int S_NONSTD = 0;
    localparam int S_EXT    = 1;
    localparam int S_ARMED  = 2;
    localparam int S_BUSY   = 3;
    localparam int S_DF     = 4;
    // ----------------------------------------------------------------
    // Packet and video constants
    // ----------------------------------------------------------------
    localparam int         UDW_DEPTH = 255;
    localparam logic [7:0] UDW_LAST  = 8'hfe;
    localparam logic [9:0] BLACK_Y   = 10'h040;
    localparam logic [9:0] BLACK_C   = 10'h200;
    typedef enum logic [1:0] {
        PM_OFF    = 2'b00,
        PM_CONT   = 2'b01,
        PM_SINGLE = 2'b10
    } soatc_mode_t;
    typedef enum logic [2:0] {
        PK_IDLE = 3'b000,
        PK_DID  = 3'b001,
        PK_SECONDARY_IDENTIFIER_WORD = 3'b010,
        PK_DC   = 3'b011,
        PK_UDW  = 3'b100,
        PK_CS   = 3'b101
    } soatc_pkt_t;
endpackage
`default_nettype wire

// *** rtl/soatc_top.sv ***
/*
 Output-stage control for a generated serial video stream: timecode source,
 component gates, edge filter, sync cycling and a user ancillary packet.
 Assumes one 10 MHz clock, synchronous video words and an AHB-Lite master.
*/
// Summary of operation
// - timecode from program counter or external daytime
// - apply loads initial time without external module
// - external time gets programmable offset added
// - drop frame only at non-integer rates
// - linear timecode packets only when enabled
// - vertical timecode packets only when enabled
// - each of three components has own gate
// - non-default video settings flag non-standard signal
// - edge filter smooths transitions, bypass is instantaneous
// - signals without filter pass unchanged
// - sync cycling: one second on, four black
// - packet never overwrites audio or CRC
// - packet order: ids, count, words, checksum
// - word store index 0 to 254
// - packet mode off, continuous or single
// - automatic parity sends low eight bits only
// - stored words keep all ten bits
// - identifier accepts eight or ten bit values
// - secondary identifier accepts eight or ten bits
// - out-of-range placement suppresses packet
`default_nettype none
module soatc_top #(
    parameter int unsigned AV_ON_CYCLES  = soatc_pkg::AV_ON_CYC,
    parameter int unsigned AV_OFF_CYCLES = soatc_pkg::AV_OFF_CYC
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    // Timecode sources
    input  wire logic        ext_present,
    input  wire logic [31:0] ext_time,
    input  wire logic        frac_rate,
    // Generated video in
    input  wire logic        vid_valid,
    input  wire logic        vid_frame_start,
    input  wire logic        vid_active,
    input  wire logic        vid_rgb,
    input  wire logic        vid_has_filter,
    input  wire logic        vid_protected,
    input  wire logic [10:0] vid_line,
    input  wire logic [11:0] vid_sample,
    input  wire logic [9:0]  vid_c0,
    input  wire logic [9:0]  vid_c1,
    input  wire logic [9:0]  vid_c2,
    input  wire logic [10:0] fmt_max_line,
    input  wire logic [11:0] fmt_max_sample,
    // Video out to serializer
    output var  logic        out_valid,
    output var  logic [9:0]  out_c0,
    output var  logic [9:0]  out_c1,
    output var  logic [9:0]  out_c2,
    output var  logic        out_anc,
    output var  logic        audio_mute,
    output var  logic        nonstd,
    output var  logic [31:0] tc_value,
    output var  logic        ltc_insert,
    output var  logic        vitc_insert,
    output var  logic        df_active
);
    import soatc_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [31:0]       init_t;
        logic [31:0]       offs;
        logic [9:0]        data_identifier_word;
        logic [9:0]        secondary_identifier_word;
        logic [9:0]        dc;
        logic [9:0]        cs;
        logic [10:0]       line;
        logic [11:0]       samp;
        logic [7:0]        idx;
        logic [31:0]       prog;
        logic [31:0]       tc;
        logic              ltc;
        logic              vitc;
        logic              df;
        logic              nonstd;
        logic              mute;
        logic [7:0]        a_addr;
        logic              a_wr;
        logic              a_rd;
        logic [31:0]       rdata;
        logic              rdy;
        logic              resp;
        logic [AV_W-1:0]   av_cnt;
        logic              av_off;
        logic              armed;
        soatc_pkt_t        st;
        logic [7:0]        k;
        logic [8:0]        sum;
        logic              ov;
        logic [9:0]        o0;
        logic [9:0]        o1;
        logic [9:0]        o2;
        logic              oanc;
        logic [9:0]        p0;
        logic [9:0]        p1;
        logic [9:0]        p2;
    } soatc_state_t;

    soatc_state_t s;
    soatc_state_t n;
    logic [9:0]   udw_mem [UDW_DEPTH];
    logic [9:0]   mem_w;
    logic [9:0]   mem_r;
    logic         ctrl_wr;
    logic         start;
    soatc_pkt_t   pk_cur;
    logic [9:0]   w;
    logic [7:0]   cnt;

    // Parity is regenerated from the low byte into bits 9:8 unless man is set, which keeps stored bits 9:8 intact.
    function automatic logic [9:0] fmt_word(input logic [9:0] v, input logic man);
        logic p;
        p = ^v[7:0];
        return man ? v : {~p, p, v[7:0]};
    endfunction

    function automatic logic [9:0] edge_f(input logic [9:0] c, input logic [9:0] p, input logic en);
        logic [10:0] t;
        t = 11'({1'b0, c}) + 11'({1'b0, p});
        return (en && c != p) ? t[10:1] : c;
    endfunction

    assign ctrl_wr = s.a_wr && s.a_addr == A_CTRL;
    assign mem_w   = udw_mem[s.k];
    assign mem_r   = s.idx <= UDW_LAST ? udw_mem[s.idx] : 10'h000;
    assign cnt     = s.dc[7:0];

    // ----------------------------------------------------------------
    // User word storage
    // ----------------------------------------------------------------
    always_ff @(posedge hclk) begin
        if (s.a_wr && s.a_addr == A_UDW && hwdata[HI_LSB+7:HI_LSB] <= UDW_LAST) begin
            udw_mem[hwdata[HI_LSB+7:HI_LSB]] <= hwdata[9:0];
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n      = s;
        n.ltc  = 1'b0;
        n.vitc = 1'b0;
        n.a_wr = 1'b0;
        n.resp = 1'b0;
        w      = 10'h000;
        // Bus: writes land in the data phase, reads insert one wait state.
        if (s.a_rd) begin
            n.a_rd = 1'b0;
            n.rdy  = 1'b1;
            if (s.a_addr == A_CTRL) begin
                n.rdata = {18'h00000, s.ctrl};
            end else if (s.a_addr == A_INIT) begin
                n.rdata = s.init_t;
            end else if (s.a_addr == A_OFFS) begin
                n.rdata = s.offs;
            end else if (s.a_addr == A_IDS) begin
                n.rdata = {6'h00, s.secondary_identifier_word, 6'h00, s.data_identifier_word};
            end else if (s.a_addr == A_CNCS) begin
                n.rdata = {6'h00, s.cs, 6'h00, s.dc};
            end else if (s.a_addr == A_LOC) begin
                n.rdata = {4'h0, s.samp, 5'h00, s.line};
            end else if (s.a_addr == A_UDW) begin
                n.rdata = {8'h00, s.idx, 6'h00, mem_r};
            end else if (s.a_addr == A_STAT) begin
                n.rdata = {27'h0000000, s.df, s.st != PK_IDLE, s.armed, ext_present, s.nonstd};
            end else if (s.a_addr == A_TC) begin
                n.rdata = s.tc;
            end else begin
                n.rdata = 32'h00000000;
            end
        end else if (hsel && htrans[1] && hready) begin
            n.a_addr = haddr[7:0];
            n.a_wr   = hwrite;
            n.a_rd   = !hwrite;
            n.rdy    = hwrite;
        end
        if (s.a_wr) begin
            if (s.a_addr == A_CTRL) begin
                n.ctrl = hwdata[CTRL_W-1:0];
                n.ctrl[C_APPLY] = 1'b0;
            end else if (s.a_addr == A_INIT) begin
                n.init_t = hwdata;
            end else if (s.a_addr == A_OFFS) begin
                n.offs = hwdata;
            end else if (s.a_addr == A_IDS) begin
                n.data_identifier_word  = hwdata[9:0];
                n.secondary_identifier_word = hwdata[HI_LSB+9:HI_LSB];
            end else if (s.a_addr == A_CNCS) begin
                n.dc = hwdata[9:0];
                n.cs = hwdata[HI_LSB+9:HI_LSB];
            end else if (s.a_addr == A_LOC) begin
                n.line = hwdata[10:0];
                n.samp = hwdata[HI_LSB+11:HI_LSB];
            end else if (s.a_addr == A_UDW) begin
                n.idx = hwdata[HI_LSB+7:HI_LSB];
            end
        end

        // Timecode.
        if (vid_valid && vid_frame_start) begin
            n.prog = s.prog + 32'h00000001;
            n.ltc  = s.ctrl[C_LTC];
            n.vitc = s.ctrl[C_VITC];
        end
        if (ctrl_wr && hwdata[C_APPLY] && !ext_present) begin
            n.prog = s.init_t;
        end
        if (s.ctrl[C_SRC] && ext_present) begin
            n.tc = ext_time + s.offs;
        end else begin
            n.tc = s.prog;
        end
        n.df     = s.ctrl[C_DF] && frac_rate;
        n.nonstd = s.ctrl[C_COMP+2:C_COMP] != COMP_ALL_ON || !s.ctrl[C_EDGE] || s.ctrl[C_AV];

        // Sync cycling: the black phase restarts the one-second lit phase.
        if (s.ctrl[C_AV]) begin
            n.av_cnt = s.av_cnt + 26'h0000001;
            if (s.av_off && s.av_cnt == AV_W'(AV_OFF_CYCLES - 1)) begin
                n.av_cnt = '0;
                n.av_off = 1'b0;
            end else if (!s.av_off && s.av_cnt == AV_W'(AV_ON_CYCLES - 1)) begin
                n.av_cnt = '0;
                n.av_off = 1'b1;
            end
        end else begin
            n.av_cnt = '0;
            n.av_off = 1'b0;
        end
        n.mute = s.av_off;

        // Packet inserter.
        start = s.st == PK_IDLE && vid_valid && vid_line == s.line && vid_sample == s.samp
                && s.line <= fmt_max_line && s.samp <= fmt_max_sample
                && (s.ctrl[C_MODE+1:C_MODE] == PM_CONT
                    || (s.ctrl[C_MODE+1:C_MODE] == PM_SINGLE && s.armed));
        pk_cur = start ? PK_DID : s.st;
        if (start) begin
            n.armed = 1'b0;
        end
        if (ctrl_wr && hwdata[C_MODE+1:C_MODE] == PM_SINGLE) begin
            n.armed = 1'b1;
        end

        n.ov = vid_valid;
        n.oanc = 1'b0;
        if (vid_valid) begin
            n.p0 = vid_c0;
            n.p1 = vid_c1;
            n.p2 = vid_c2;
            n.o0 = edge_f(vid_c0, s.p0, vid_has_filter && s.ctrl[C_EDGE]);
            n.o1 = edge_f(vid_c1, s.p1, vid_has_filter && s.ctrl[C_EDGE]);
            n.o2 = edge_f(vid_c2, s.p2, vid_has_filter && s.ctrl[C_EDGE]);
            if (vid_active) begin
                if (!s.ctrl[C_COMP] || s.av_off) begin
                    n.o0 = BLACK_Y;
                end
                if (!s.ctrl[C_COMP+1] || s.av_off) begin
                    n.o1 = vid_rgb ? BLACK_Y : BLACK_C;
                end
                if (!s.ctrl[C_COMP+2] || s.av_off) begin
                    n.o2 = vid_rgb ? BLACK_Y : BLACK_C;
                end
            end
            // A protected word delays the packet rather than being replaced.
            if (pk_cur != PK_IDLE && !vid_protected) begin
                case (pk_cur)
                    PK_DID: begin
                        w    = fmt_word(s.data_identifier_word, s.ctrl[C_MAN]);
                        n.st = PK_SECONDARY_IDENTIFIER_WORD;
                    end
                    PK_SECONDARY_IDENTIFIER_WORD: begin
                        w    = fmt_word(s.secondary_identifier_word, s.ctrl[C_MAN]);
                        n.st = PK_DC;
                    end
                    PK_DC: begin
                        w    = fmt_word(s.dc, s.ctrl[C_MAN]);
                        n.k  = 8'h00;
                        n.st = cnt == 8'h00 ? PK_CS : PK_UDW;
                    end
                    PK_UDW: begin
                        w    = fmt_word(mem_w, s.ctrl[C_MAN]);
                        n.k  = s.k + 8'h01;
                        n.st = s.k == cnt - 8'h01 ? PK_CS : PK_UDW;
                    end
                    PK_CS: begin
                        w    = s.ctrl[C_CSA] ? {~s.sum[8], s.sum} : fmt_word(s.cs, s.ctrl[C_MAN]);
                        n.st = PK_IDLE;
                    end
                    default: begin
                        n.st = PK_IDLE;
                    end
                endcase
                n.sum  = pk_cur == PK_DID ? w[8:0] : s.sum + w[8:0];
                n.o0   = w;
                n.oanc = 1'b1;
            end else if (start) begin
                n.st = PK_DID;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s        <= '0;
            s.ctrl   <= CTRL_RST;
            s.rdy    <= 1'b1;
            s.o1     <= BLACK_C;
            s.o2     <= BLACK_C;
            s.o0     <= BLACK_Y;
        end else begin
            s <= n;
        end
    end

    assign hrdata      = s.rdata;
    assign hreadyout   = s.rdy;
    assign hresp       = s.resp;
    assign out_valid   = s.ov;
    assign out_c0      = s.o0;
    assign out_c1      = s.o1;
    assign out_c2      = s.o2;
    assign out_anc     = s.oanc;
    assign audio_mute  = s.mute;
    assign nonstd      = s.nonstd;
    assign tc_value    = s.tc;
    assign ltc_insert  = s.ltc;
    assign vitc_insert = s.vitc;
    assign df_active   = s.df;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    apply_load_a: assert property (ctrl_wr && hwdata[C_APPLY] && !ext_present |=> s.prog == $past(s.init_t))
        else $error("apply did not load initial time");
    src_prog_a: assert property (!ext_present |=> tc_value == $past(s.prog))
        else $error("program time not selected without external source");
    tc_offset_a: assert property (s.ctrl[C_SRC] && ext_present |=> tc_value == $past(ext_time) + $past(s.offs))
        else $error("external time offset wrong");
    df_gate_a: assert property (!frac_rate |=> !df_active)
        else $error("drop frame active at integer rate");
    ltc_gate_a: assert property (!s.ctrl[C_LTC] |=> !ltc_insert)
        else $error("linear timecode inserted while disabled");
    vitc_gate_a: assert property (!s.ctrl[C_VITC] |=> !vitc_insert)
        else $error("vertical timecode inserted while disabled");
    nonstd_flag_a: assert property (s.ctrl[C_COMP+2:C_COMP] != COMP_ALL_ON |=> nonstd)
        else $error("non-standard flag missing");
    gate_black_a: assert property (vid_valid && vid_active && !s.ctrl[C_COMP+1]
        |=> out_c1 == ($past(vid_rgb) ? BLACK_Y : BLACK_C))
        else $error("gated component not black");
    nofilt_pass_a: assert property (vid_valid && !vid_active && !vid_has_filter |=> out_c2 == $past(vid_c2))
        else $error("unfiltered signal altered");
    protect_a: assert property (vid_valid && vid_protected |=> !out_anc)
        else $error("protected word overwritten");
    range_a: assert property (s.st == PK_IDLE && (s.line > fmt_max_line || s.samp > fmt_max_sample)
        |=> s.st == PK_IDLE)
        else $error("packet placed outside allowed range");
    parity_a: assert property (vid_valid && !vid_protected && pk_cur == PK_UDW && !s.ctrl[C_MAN]
        |=> out_c0[8] == ^out_c0[7:0] && out_c0[9] != out_c0[8])
        else $error("automatic parity bits wrong");
    av_phase_a: assert property ($rose(s.av_off) |-> $past(s.av_cnt) == AV_W'(AV_ON_CYCLES - 1))
        else $error("sync cycle lit phase length wrong");
    single_once_a: assert property (start && s.ctrl[C_MODE+1:C_MODE] == PM_SINGLE && !ctrl_wr |=> !s.armed)
        else $error("single packet re-armed without selection");
endmodule
`default_nettype wire

// *** testbench/soatc_vid_src.sv ***
/*
 Behavioural pattern source that feeds the output stage.
 Assumes the bench seeds $urandom; the raster is 16 samples by 8 lines.
*/
`default_nettype none
module soatc_vid_src (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Video words
    output var  logic        vid_valid,
    output var  logic        vid_frame_start,
    output var  logic        vid_active,
    output var  logic        vid_has_filter,
    output var  logic        vid_protected,
    output var  logic [10:0] vid_line,
    output var  logic [11:0] vid_sample,
    output var  logic [9:0]  vid_c0,
    output var  logic [9:0]  vid_c1,
    output var  logic [9:0]  vid_c2
);
    timeunit 1ns;
    timeprecision 1ns;
    // The last sample stands for audio or CRC words, which must never be replaced.
    assign vid_protected   = (vid_sample == 12'hf);
    assign vid_active      = (vid_sample >= 12'h4);
    assign vid_frame_start = (vid_sample == 12'h0) && (vid_line == 11'h0);
    assign vid_has_filter  = vid_line[0];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vid_valid  <= 1'b0;
            vid_sample <= 12'h0;
            vid_line   <= 11'h0;
        end else begin
            vid_valid  <= 1'b1;
            vid_sample <= vid_protected ? 12'h0 : vid_sample + 12'h1;
            vid_line   <= (vid_line + 11'(vid_protected)) & 11'h7;
        end
        vid_c0 <= 10'($urandom);
        vid_c1 <= 10'($urandom);
        vid_c2 <= 10'($urandom);
    end
endmodule
`default_nettype wire

// *** testbench/sdi_output_anc_timecode_ctrl_tb.sv ***
/*
 Self-checking bench for the output stage control block.
 Assumes soatc_pkg, soatc_top and soatc_vid_src are compiled first.
*/
`default_nettype none
module sdi_output_anc_timecode_ctrl_tb import soatc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int AVOFF = 40;
    logic        hclk, hresetn, hsel, hwrite, ext_present, frac_rate, hreadyout, hresp;
    logic        vv, fs, act, hf, pr, ov, oa, mute, nonstd, ltc, vitc, dfa, rgb;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, ext_time, q, tc_value, off, init;
    logic [10:0] ln, fml;
    logic [11:0] sm, fms;
    logic [9:0]  c0, c1, c2, o0, o1, o2, data_identifier_word, secondary_identifier_word, payload_words;
    int          n_errors, total_checks, a, l, v, i;
    soatc_top #(.AV_ON_CYCLES(10), .AV_OFF_CYCLES(AVOFF)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ext_present(ext_present), .ext_time(ext_time), .frac_rate(frac_rate),
        .vid_valid(vv), .vid_frame_start(fs), .vid_active(act), .vid_rgb(rgb), .vid_has_filter(hf),
        .vid_protected(pr), .vid_line(ln), .vid_sample(sm), .vid_c0(c0), .vid_c1(c1), .vid_c2(c2),
        .fmt_max_line(fml), .fmt_max_sample(fms), .out_valid(ov), .out_c0(o0), .out_c1(o1),
        .out_c2(o2), .out_anc(oa), .audio_mute(mute), .nonstd(nonstd), .tc_value(tc_value),
        .ltc_insert(ltc), .vitc_insert(vitc), .df_active(dfa));
    soatc_vid_src u_src (
        .hclk(hclk), .hresetn(hresetn), .vid_valid(vv), .vid_frame_start(fs), .vid_active(act),
        .vid_has_filter(hf), .vid_protected(pr), .vid_line(ln), .vid_sample(sm), .vid_c0(c0),
        .vid_c1(c1), .vid_c2(c2));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    function automatic logic [9:0] fmt(input logic [9:0] w, input logic man);
        return man ? w : {~(^w[7:0]), ^w[7:0], w[7:0]};
    endfunction
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Address phase is held until hready, then the data phase until hready again.
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int k;
        hsel   <= 1'b1;
        haddr  <= {24'h0, ad};
        htrans <= 2'h2;
        hwrite <= w;
        repeat (2) begin
            k = 0;
            do begin
                @(posedge hclk);
                k++;
            end while (hreadyout !== 1'b1 && k < 50);
            if (k >= 50) begin
                n_errors++;
                print_verdict();
            end
            htrans <= 2'h0;
            hwdata <= d;
        end
        q = hrdata;
    endtask
    task automatic cnt();
        a = 0;
        l = 0;
        v = 0;
        repeat (300) begin
            @(posedge hclk);
            a += int'(oa === 1'b1);
            l += int'(ltc === 1'b1);
            v += int'(vitc === 1'b1);
        end
    endtask
    task automatic pkt(input logic man);
        logic [9:0] w [5];
        logic [8:0] s;
        w[0] = fmt(data_identifier_word, man);
        w[1] = fmt(secondary_identifier_word, man);
        w[2] = fmt(10'h001, man);
        w[3] = fmt(payload_words, man);
        s = w[0][8:0] + w[1][8:0] + w[2][8:0] + w[3][8:0];
        w[4] = {~s[8], s};
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (oa !== 1'b1 && i < 400);
        if (i >= 400) begin
            n_errors++;
            print_verdict();
        end
        for (int k = 0; k < 5; k++) begin
            chk({oa, o0}, {1'b1, w[k]}, "packet word");
            @(posedge hclk);
        end
    endtask
    task automatic vchk(input logic g, input logic ef);
        logic       pa, ph, rg;
        logic [9:0] p1, q1;
        pa = 1'b0;
        ph = 1'b0;
        rg = 1'b0;
        p1 = c1;
        q1 = c1;
        repeat (40) begin
            @(posedge hclk);
            if (pa && g) begin
                chk({ov, o0, o1, o2}, {1'b1, BLACK_Y, {2{rg ? BLACK_Y : BLACK_C}}}, "gated");
            end else if (pa) begin
                chk(o1, (ph && ef && p1 != q1) ? 10'((11'(p1) + 11'(q1)) >> 1) : p1, "filter");
            end
            pa = act && !pr;
            ph = hf;
            rg = rgb;
            q1 = p1;
            p1 = c1;
            rgb <= 1'($urandom);
        end
    endtask
    initial begin
        {hsel, hwrite, ext_present, frac_rate, rgb, htrans, haddr, hwdata, ext_time} = '0;
        {hresetn, hsize, fml, fms, n_errors, total_checks} = {1'b0, 3'h2, 11'h7, 12'hf, 64'h0};
        void'($urandom(32'hf910));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, A_CTRL, 0);
        chk(q, 32'h1e0, "ctrl reset");
        bus(1, A_UDW, 32'h00ff0155);
        bus(0, A_UDW, 0);
        chk(q, 32'h00ff0000, "word 255");
        bus(0, 8'h40, 0);
        chk(q | 32'(hresp), 0, "unmapped");
        data_identifier_word  = 10'h3ff;
        secondary_identifier_word = 10'($urandom);
        payload_words  = 10'($urandom);
        bus(1, A_IDS, {6'h0, secondary_identifier_word, 6'h0, data_identifier_word});
        bus(1, A_CNCS, 32'h1);
        bus(1, A_LOC, 32'h00050002);
        bus(1, A_UDW, {22'h0, payload_words});
        bus(0, A_UDW, 0);
        chk(q, {22'h0, payload_words}, "stored word");
        for (int m = 0; m < 2; m++) begin
            bus(1, A_CTRL, 32'h25e0 | (m << 12));
            pkt(m[0]);
        end
        bus(1, A_CTRL, 32'h29e0);
        pkt(1'b0);
        cnt();
        chk(a, 0, "single repeat");
        fml <= 11'h1;
        bus(1, A_CTRL, 32'h25e0);
        cnt();
        chk(a, 0, "out of range");
        fml <= 11'h7;
        bus(1, A_CTRL, 32'h21e0);
        cnt();
        chk(a, 0, "mode off");
        for (int m = 0; m < 2; m++) begin
            bus(1, A_CTRL, m ? 32'h1f0 : 32'h1e8);
            cnt();
            chk({l > 0, v > 0}, m ? 2'b01 : 2'b10, "tc inserts");
        end
        bus(1, A_CTRL, 32'h100);
        vchk(1'b1, 1'b1);
        chk(nonstd, 1, "gates nonstd");
        bus(1, A_CTRL, 32'h0e0);
        vchk(1'b0, 1'b0);
        chk(nonstd, 1, "edge nonstd");
        bus(1, A_CTRL, 32'h1e0);
        vchk(1'b0, 1'b1);
        chk(nonstd, 0, "default std");
        {off, init} = {$urandom, $urandom};
        ext_present <= 1'b1;
        ext_time    <= $urandom;
        bus(1, A_OFFS, off);
        bus(1, A_CTRL, 32'h1e1);
        repeat (4) @(posedge hclk);
        chk(tc_value, ext_time + off, "ext time");
        ext_present <= 1'b0;
        bus(1, A_INIT, init);
        bus(1, A_CTRL, 32'h1e2);
        repeat (3) @(posedge hclk);
        chk(32'(tc_value - init <= 32'h1), 1, "apply");
        for (int m = 0; m < 2; m++) begin
            frac_rate <= m[0];
            bus(1, A_CTRL, 32'h1e4);
            repeat (3) @(posedge hclk);
            chk(dfa, m, "drop frame");
        end
        bus(1, A_CTRL, 32'h3e0);
        for (i = 0; i < 100 && mute !== 1'b1; i++) @(posedge hclk);
        for (i = 0; i < 100 && mute === 1'b1; i++) @(posedge hclk);
        chk(i, AVOFF, "black phase");
        print_verdict();
    end
endmodule
`default_nettype wire
